// file: design/cto_pkg.sv
// package for the second comparator control and output path
// assumes a 32-bit classic wishbone slave and 8-bit comparator registers
package cto_pkg;

   // ************************************************
   // register map (byte addresses)
   // ************************************************
   localparam logic [7:0] CTO_ADR_CTRL0 = 8'h00;  // comparator_two_control_zero
   localparam logic [7:0] CTO_ADR_CTRL1 = 8'h04;  // comparator_two_control_one
   localparam logic [7:0] CTO_ADR_IRQST = 8'h08;  // sticky event status, write one to clear
   localparam logic [7:0] CTO_ADR_IRQMK = 8'h0C;  // event mask
   localparam logic [7:0] CTO_ADR_PORTV = 8'h10;  // port read view

   // ************************************************
   // field positions
   // ************************************************
   localparam int CTO_C0_ENABLE = 7;
   localparam int CTO_C0_RESULT = 6;
   localparam int CTO_C0_DRIVE  = 5;
   localparam int CTO_C0_INVERT = 4;
   localparam int CTO_C0_REFSEL = 2;
   localparam int CTO_C0_CHLO   = 0;
   localparam int CTO_C1_MIRA   = 7;
   localparam int CTO_C1_MIRB   = 6;
   localparam int CTO_C1_GATSEL = 1;
   localparam int CTO_C1_SYNC   = 0;
   localparam int CTO_EV_CHANGE = 0;
   localparam int CTO_EV_GATE   = 1;

   // ************************************************
   // writable masks and reset values
   // ************************************************
   localparam logic [7:0] CTO_C0_WMASK = 8'hB7;
   localparam logic [7:0] CTO_C0_RST   = 8'h00;
   localparam logic [7:0] CTO_C1_WMASK = 8'h03;
   localparam logic [7:0] CTO_C1_RST   = 8'h02;
   localparam logic [1:0] CTO_EV_RST   = 2'h0;

   // ************************************************
   // types
   // ************************************************
   typedef enum logic [1:0] {
      CTO_BUS_IDLE = 2'b00,
      CTO_BUS_ACK  = 2'b01
   } cto_bus_e;

   // sampled analog levels, one code per source
   typedef struct packed {
      logic [7:0]      refLevel;   // internal reference
      logic [7:0]      posPin;     // external non-inverting pin
      logic [3:0][7:0] chanPin;    // four inverting channel pins
   } cto_analog_s;

   // timer clock sources seen by the capture logic
   typedef struct packed {
      logic rawClk;
      logic prescaledClk;
      logic prescaleOn;
   } cto_tmrclk_s;

endpackage : cto_pkg

// file: design/cto_comparator_two_output_control.sv
// control, output path, timer gating and mirror read of the second comparator
// assumes all inputs synchronous to clk_sys; timer clock pins are sampled levels
//
// The Wishbone interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module cto_comparator_two_output_control
(
   input  wire logic               clk_sys,          // 10 MHz system clock
   input  wire logic               rst_n,            // synchronous reset
   input  wire logic               wb_cyc_i,         // bus cycle
   input  wire logic               wb_stb_i,         // bus strobe
   input  wire logic               wb_we_i,          // write
   input  wire logic [7:0]         wb_adr_i,         // byte address
   input  wire logic [3:0]         wb_sel_i,         // byte lanes
   input  wire logic [31:0]        wb_dat_i,         // write data
   output logic      [31:0]        wb_dat_o,         // read data
   output logic                    wb_ack_o,         // acknowledge
   input  wire cto_pkg::cto_analog_s analogIn,       // sampled analog levels
   input  wire logic               cmpAResult,       // first comparator result
   input  wire logic               portDirectionBit, // port direction of output pin
   input  wire logic [3:0]         pinAnalogSel,     // pins configured analog
   input  wire logic [3:0]         pinDigitalIn,     // digital pin levels
   input  wire cto_pkg::cto_tmrclk_s tmrClk,         // timer clock sources
   input  wire logic               extGatePin,       // external timer gate level
   output logic                    cmpBPinOut,       // result toward pin
   output logic                    cmpBPinOeN,       // low while pin is driven
   output logic                    tmrGate,          // gate level to timer
   output logic                    tmrCountEdge,     // timer increment pulse
   output logic                    irq               // level interrupt
);
   import cto_pkg::*;

   // ************************************************
   // registers
   // ************************************************
   logic [7:0] ctrl0_ff;
   logic [7:0] ctrl1_ff;
   logic [1:0] irqStat_ff;
   logic [1:0] irqMask_ff;
   logic       result_ff;
   logic       mismatchRef_ff;
   logic       synced_ff;
   logic       capClkPrev_ff;
   logic       gatePrev_ff;
   logic [31:0] rdData_ff;
   cto_bus_e   busState_ff;

   // ************************************************
   // bus decode
   // ************************************************
   wire        busReq   = wb_cyc_i & wb_stb_i & (busState_ff == CTO_BUS_IDLE);
   wire        wrLane0  = busReq & wb_we_i & wb_sel_i[0];
   wire        rdReq    = busReq & ~wb_we_i;
   wire        hitCtrl0 = (wb_adr_i == CTO_ADR_CTRL0);
   wire        hitCtrl1 = (wb_adr_i == CTO_ADR_CTRL1);
   wire        hitIrqSt = (wb_adr_i == CTO_ADR_IRQST);
   wire        hitIrqMk = (wb_adr_i == CTO_ADR_IRQMK);
   wire        hitPortV = (wb_adr_i == CTO_ADR_PORTV);
   wire [7:0]  wrByte   = wb_dat_i[7:0];

   // ************************************************
   // comparator core
   // ************************************************
   wire        cmpEnable  = ctrl0_ff[CTO_C0_ENABLE];
   wire        pinDriveEn = ctrl0_ff[CTO_C0_DRIVE];
   wire        invert     = ctrl0_ff[CTO_C0_INVERT];
   wire        refSelect  = ctrl0_ff[CTO_C0_REFSEL];
   wire [1:0]  chanSel    = ctrl0_ff[CTO_C0_CHLO +: 2];
   wire        gateSel    = ctrl1_ff[CTO_C1_GATSEL];
   wire        syncEn     = ctrl1_ff[CTO_C1_SYNC];

   wire [7:0]  nonInvLevel = refSelect ? analogIn.refLevel : analogIn.posPin;
   wire [7:0]  invLevel    = analogIn.chanPin[chanSel];
   wire        aboveRaw    = (nonInvLevel > invLevel);
   // a disabled comparator reads low whatever its inputs
   wire        nxt_result  = cmpEnable & (aboveRaw ^ invert);

   // ************************************************
   // timer clock capture
   // ************************************************
   // prescaled clock replaces the raw one when the prescaler is active
   wire        capClk    = tmrClk.prescaleOn ? tmrClk.prescaledClk : tmrClk.rawClk;
   wire        capFall   = capClkPrev_ff & ~capClk;
   wire        capRise   = ~capClkPrev_ff & capClk;
   // sync off bypasses the capture stage, which still captures, so with gateSel clear the gate sees only the live result
   wire        syncedOut = syncEn ? synced_ff : result_ff;
   wire        nxt_gate  = gateSel ? extGatePin : syncedOut;

   // ************************************************
   // events
   // ************************************************
   wire        evChange = (result_ff != mismatchRef_ff);
   wire        evGate   = (syncedOut != gatePrev_ff);
   wire [1:0]  events;
   assign events[CTO_EV_CHANGE] = evChange;
   assign events[CTO_EV_GATE]   = evGate;
   wire [1:0]  irqClr    = (wrLane0 & hitIrqSt) ? wrByte[1:0] : 2'h0;
   // a new event in the clearing cycle survives the clear
   wire [1:0]  nxt_irqSt = (irqStat_ff & ~irqClr) | events;

   // ************************************************
   // read mux
   // ************************************************
   wire [7:0]  ctrl0View = {ctrl0_ff[7], result_ff, ctrl0_ff[5:0]};
   wire [7:0]  ctrl1View = {cmpAResult, result_ff, 4'h0, ctrl1_ff[1:0]};
   wire [7:0]  portView  = {4'h0, pinDigitalIn & ~pinAnalogSel};
   wire [7:0]  rdByte    = hitCtrl0 ? ctrl0View :
                           hitCtrl1 ? ctrl1View :
                           hitIrqSt ? {6'h00, irqStat_ff} :
                           hitIrqMk ? {6'h00, irqMask_ff} :
                           hitPortV ? portView : 8'h00;

   // only a read of the primary register refreshes the mismatch reference
   wire        refreshRef = rdReq & hitCtrl0;

   // ************************************************
   // sequential logic
   // ************************************************
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         ctrl0_ff <= CTO_C0_RST;
         ctrl1_ff <= CTO_C1_RST;
      end else begin
         if (wrLane0 & hitCtrl0) begin
            ctrl0_ff <= wrByte & CTO_C0_WMASK;
         end
         if (wrLane0 & hitCtrl1) begin
            ctrl1_ff <= wrByte & CTO_C1_WMASK;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         irqStat_ff <= CTO_EV_RST;
         irqMask_ff <= CTO_EV_RST;
      end else begin
         irqStat_ff <= nxt_irqSt;
         if (wrLane0 & hitIrqMk) begin
            irqMask_ff <= wrByte[1:0];
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         result_ff      <= 1'b0;
         mismatchRef_ff <= 1'b0;
         gatePrev_ff    <= 1'b0;
      end else begin
         result_ff   <= nxt_result;
         gatePrev_ff <= syncedOut;
         if (refreshRef) begin
            mismatchRef_ff <= result_ff;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         synced_ff     <= 1'b0;
         capClkPrev_ff <= 1'b0;
      end else begin
         capClkPrev_ff <= capClk;
         if (capFall) begin
            synced_ff <= result_ff;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         busState_ff <= CTO_BUS_IDLE;
         rdData_ff   <= 32'h0000_0000;
      end else begin
         case (busState_ff)
            CTO_BUS_IDLE: begin
               if (busReq) begin
                  busState_ff <= CTO_BUS_ACK;
                  rdData_ff   <= {24'h00_0000, rdByte};
               end
            end
            default: begin
               busState_ff <= CTO_BUS_IDLE;
            end
         endcase
      end
   end

   // ************************************************
   // outputs
   // ************************************************
   wire pinDrive = pinDriveEn & cmpEnable & ~portDirectionBit;
   assign cmpBPinOut   = result_ff;
   assign cmpBPinOeN   = ~pinDrive;
   assign tmrGate      = nxt_gate;
   // count on the rising edge so capture and count never share an edge
   assign tmrCountEdge = capRise;
   assign irq          = |(irqStat_ff & irqMask_ff);
   assign wb_ack_o     = (busState_ff == CTO_BUS_ACK);
   assign wb_dat_o     = rdData_ff;

   // ************************************************
   // assertions
   // ************************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   a_pin_drive_cond: assert property (!cmpBPinOeN |-> (ctrl0_ff[CTO_C0_DRIVE] && ctrl0_ff[CTO_C0_ENABLE]
                                       && !portDirectionBit))
      else $error("pin driven without all three conditions");

   a_polarity_result: assert property (##1 result_ff == ($past(ctrl0_ff[CTO_C0_ENABLE])
                                       && ($past(aboveRaw) != $past(ctrl0_ff[CTO_C0_INVERT]))))
      else $error("result does not follow comparison and polarity");

   a_gate_comparator: assert property (!ctrl1_ff[CTO_C1_GATSEL] && !ctrl1_ff[CTO_C1_SYNC]
                                       |-> tmrGate == result_ff)
      else $error("gate does not follow comparator");

   a_gate_external: assert property (ctrl1_ff[CTO_C1_GATSEL] |-> tmrGate == extGatePin)
      else $error("gate does not follow external pin");

   a_sync_capture: assert property (capFall && ctrl1_ff[CTO_C1_SYNC] && !ctrl1_ff[CTO_C1_GATSEL]
                                       ##1 !capFall |-> tmrGate == $past(result_ff))
      else $error("captured value not presented");

   a_sync_hold: assert property (ctrl1_ff[CTO_C1_SYNC] && !capFall |=> $stable(synced_ff))
      else $error("capture changed away from falling edge");

   a_presc_source: assert property (tmrClk.prescaleOn && tmrClk.rawClk != tmrClk.prescaledClk
                                       |-> capClk == tmrClk.prescaledClk)
      else $error("capture clock not from prescaler");

   a_edges_apart: assert property (tmrCountEdge |-> !capFall)
      else $error("count and capture on same edge");

   a_mirror_read: assert property (rdReq && hitCtrl1 |=> wb_ack_o
                                       && wb_dat_o[7:6] == $past({cmpAResult, result_ff}))
      else $error("mirror read wrong");

   a_mirror_noref: assert property (rdReq && hitCtrl1 |=> $stable(mismatchRef_ff))
      else $error("mirror read moved mismatch state");

   a_port_analog: assert property (rdReq && hitPortV |=> (wb_dat_o[3:0] & $past(pinAnalogSel)) == 4'h0)
      else $error("analog pin read nonzero");

   a_result_ro: assert property (wrLane0 && hitCtrl0 |=> ctrl0_ff[CTO_C0_RESULT] == 1'b0)
      else $error("result bit became writable");

   a_irq_setwins: assert property (events != 2'h0 |=> (irqStat_ff & $past(events)) == $past(events))
      else $error("event lost");

   c_gate_sync: cover property (ctrl1_ff[CTO_C1_SYNC] && !ctrl1_ff[CTO_C1_GATSEL] && capFall);
   c_pin_drive: cover property (!cmpBPinOeN && cmpBPinOut);
   c_mirror_rd: cover property (rdReq && hitCtrl1);
   c_irq_fire:  cover property ($rose(irq));

endmodule // cto_comparator_two_output_control

`default_nettype wire

// file: sim/cto_timer_port_model.sv
// timer gate logic and port pin model at the far side of the comparator block
// assumes clk_sys timing; the bench starts and stops both timer clocks
`timescale 1ns/1ps
`default_nettype none
module cto_timer_port_model (
   input  wire logic       clk_sys,      // system clock
   input  wire logic       rst_n,        // sync reset
   input  wire logic       runRaw,       // raw clock runs
   input  wire logic       runPre,       // prescaled clock runs
   input  wire logic       tmrGate,      // gate from block
   input  wire logic       tmrCountEdge, // increment pulse
   input  wire logic       pinOut,       // result toward pin
   input  wire logic       pinOeN,       // low while driven
   input  wire logic       cntClr,       // clear count
   output logic            rawClk,       // raw timer clock
   output logic            preClk,       // prescaled clock
   output logic            pinLevel,     // level on the pin
   output logic [7:0]      tmrCnt        // timer count
);
   logic [1:0] divRaw;
   logic [1:0] divPre;
   logic       lastDrv;
   // clocks stand still low outside a run, period 8 cycles
   always_ff @(posedge clk_sys) begin
      divRaw <= runRaw ? divRaw + 2'h1 : 2'h0;
      divPre <= runPre ? divPre + 2'h1 : 2'h0;
      rawClk <= runRaw & (rawClk ^ (divRaw == 2'h3));
      preClk <= runPre & (preClk ^ (divPre == 2'h3));
      if (!rst_n || cntClr) begin
         tmrCnt <= 8'h00;
      end else if (tmrCountEdge && tmrGate) begin
         tmrCnt <= tmrCnt + 8'h01;
      end
      if (!rst_n) begin
         lastDrv <= 1'b0;
      end else if (!pinOeN) begin
         lastDrv <= pinOut;
      end
   end
   // released pin shows the inverse of the last driven level
   assign pinLevel = pinOeN ? ~lastDrv : pinOut;
endmodule // cto_timer_port_model
`default_nettype wire

// file: sim/testbench.sv
// register-level bench for the second comparator control block
// assumes the timer and pin model of cto_timer_port_model
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import cto_pkg::*;
   logic clk_sys, rst_n, wbCyc, wbStb, wbWe, wbAck, cmpAResult, portDirectionBit, extGatePin;
   logic cmpBPinOut, cmpBPinOeN, tmrGate, tmrCountEdge, irq, rawClk, preClk, pinLevel;
   logic runRaw, runPre, cntClr, prescaleOn;
   logic [7:0] wbAdr, tmrCnt;
   logic [31:0] wbDat, wbRdat;
   logic [3:0] pinAnalogSel, pinDigitalIn, wbSel, selReq;
   cto_analog_s analogIn;
   cto_tmrclk_s tmrClk;
   int error_cnt, checks_done, i;
   logic e;
   assign tmrClk = {rawClk, preClk, prescaleOn};
   cto_comparator_two_output_control uut (.clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
      .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDat), .wb_dat_o(wbRdat), .wb_ack_o(wbAck),
      .analogIn(analogIn), .cmpAResult(cmpAResult), .portDirectionBit(portDirectionBit),
      .pinAnalogSel(pinAnalogSel), .pinDigitalIn(pinDigitalIn), .tmrClk(tmrClk), .extGatePin(extGatePin),
      .cmpBPinOut(cmpBPinOut), .cmpBPinOeN(cmpBPinOeN), .tmrGate(tmrGate), .tmrCountEdge(tmrCountEdge),
      .irq(irq));
   cto_timer_port_model far (.clk_sys(clk_sys), .rst_n(rst_n), .runRaw(runRaw), .runPre(runPre),
      .tmrGate(tmrGate), .tmrCountEdge(tmrCountEdge), .pinOut(cmpBPinOut), .pinOeN(cmpBPinOeN),
      .cntClr(cntClr), .rawClk(rawClk), .preClk(preClk), .pinLevel(pinLevel), .tmrCnt(tmrCnt));
   always #50 clk_sys = ~clk_sys;
   // ************************************************
   // tasks
   // ************************************************
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // one classic cycle; request held until ack is sampled
   // no wait limit here: a slave that never answers is caught by the watchdog
   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
      @(posedge clk_sys);
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= w;
      wbAdr <= a;
      wbSel <= selReq;
      wbDat <= {24'h000000, d};
      do begin
         @(posedge clk_sys);
      end while (wbAck !== 1'b1);
      q = wbRdat[7:0];
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      wb(1'b1, a, d, q);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] q;
      wb(1'b0, a, 8'h00, q);
      chk(q, exp);
   endtask
   task automatic report_and_stop;
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // ************************************************
   // sequence
   // ************************************************
   initial begin
      {clk_sys, rst_n, wbCyc, wbStb, wbWe, cmpAResult, portDirectionBit, extGatePin} = 8'h00;
      {runRaw, runPre, cntClr, prescaleOn, wbAdr, wbDat, pinAnalogSel, pinDigitalIn} = 52'h0;
      analogIn = {8'h70, 8'h00, 32'hD0905010};
      wbSel = 4'h0;
      selReq = 4'h1;
      repeat (8) @(posedge clk_sys);
      rst_n <= 1'b1;
      rdc(CTO_ADR_CTRL0, CTO_C0_RST);
      rdc(CTO_ADR_CTRL1, CTO_C1_RST);
      // polarity, reference and channel; bit 6 write must not stick
      for (i = 0; i < 16; i++) begin
         e = (i[2] & (i[1:0] < 2)) ^ i[3];
         wr(CTO_ADR_CTRL0, {2'b11, 1'b0, i[3], 1'b0, i[2:0]});
         rdc(CTO_ADR_CTRL0, {1'b1, e, 1'b0, i[3], 1'b0, i[2:0]});
      end
      for (i = 0; i < 8; i++) begin
         portDirectionBit <= i[0];
         wr(CTO_ADR_CTRL0, {i[2], 1'b0, i[1], 5'h04});
         @(negedge clk_sys);
         chk(cmpBPinOeN, !(i[2] & i[1] & !i[0]));
         if (cmpBPinOeN === 1'b0) chk(pinLevel, 1'b1);
      end
      rdc(CTO_ADR_CTRL0, 8'hE4);
      // a write without lane 0 is acked but must leave the register alone
      selReq = 4'h2;
      wr(CTO_ADR_CTRL0, 8'h00);
      selReq = 4'h1;
      rdc(CTO_ADR_CTRL0, 8'hE4);
      wr(CTO_ADR_IRQMK, 8'h01);
      wr(CTO_ADR_IRQST, 8'hFF);
      analogIn.refLevel <= 8'h00;
      cmpAResult <= 1'b1;
      repeat (3) @(posedge clk_sys);
      rdc(CTO_ADR_IRQST, 8'h03);
      chk(irq, 1'b1);
      wr(CTO_ADR_IRQMK, 8'h00);
      @(negedge clk_sys);
      chk(irq, 1'b0);
      wr(CTO_ADR_IRQMK, 8'h01);
      rdc(CTO_ADR_CTRL1, 8'h82);
      // gate-level bit clears, mismatch bit is set again in the clearing cycle
      wr(CTO_ADR_IRQST, 8'h03);
      rdc(CTO_ADR_IRQST, 8'h01);
      rdc(CTO_ADR_CTRL0, 8'hA4);
      wr(CTO_ADR_IRQST, 8'h01);
      rdc(CTO_ADR_IRQST, 8'h00);
      chk(irq, 1'b0);
      analogIn.refLevel <= 8'h70;
      pinDigitalIn <= 4'hF;
      pinAnalogSel <= 4'h5;
      repeat (3) @(posedge clk_sys);
      rdc(CTO_ADR_CTRL1, 8'hC2);
      rdc(CTO_ADR_PORTV, 8'h0A);
      wr(8'h14, 8'hFF);
      rdc(8'h14, 8'h00);
      wr(CTO_ADR_CTRL1, 8'h02);
      extGatePin <= 1'b1;
      @(negedge clk_sys);
      chk(tmrGate, 1'b1);
      wr(CTO_ADR_CTRL1, 8'h00);
      extGatePin <= 1'b0;
      @(negedge clk_sys);
      chk(tmrGate, 1'b1);
      @(posedge clk_sys);
      analogIn.refLevel <= 8'h00;
      repeat (3) @(negedge clk_sys);
      chk(tmrGate, 1'b0);
      wr(CTO_ADR_CTRL1, 8'h01);
      analogIn.refLevel <= 8'h70;
      prescaleOn <= 1'b1;
      runRaw <= 1'b1;
      repeat (40) @(posedge clk_sys);
      runRaw <= 1'b0;
      @(negedge clk_sys);
      chk(tmrGate, 1'b0);
      @(posedge clk_sys);
      runPre <= 1'b1;
      repeat (40) @(posedge clk_sys);
      runPre <= 1'b0;
      @(negedge clk_sys);
      chk(tmrGate, 1'b1);
      wr(CTO_ADR_CTRL1, 8'h02);
      extGatePin <= 1'b1;
      prescaleOn <= 1'b0;
      for (i = 0; i < 2; i++) begin
         cntClr <= !i[0];
         @(posedge clk_sys);
         cntClr <= 1'b0;
         runRaw <= 1'b1;
         repeat (80) @(posedge clk_sys);
         runRaw <= 1'b0;
         extGatePin <= 1'b0;
         repeat (4) @(posedge clk_sys);
         chk(tmrCnt, 8'h0A);
      end
      report_and_stop;
   end
   initial begin
      #2000000;
      chk(8'h00, 8'hFF);
      report_and_stop;
   end
endmodule // testbench
`default_nettype wire
